// ==== rtl/cag_pkg.sv ====
// Constants and types shared by the address generation block
package cag_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PC_W       = 15;
  localparam int unsigned PC_UPPER_W = 7;
  localparam int unsigned ABS_W      = 12;

  // ****************************************************************
  // Data memory map
  // ****************************************************************
  localparam logic [7:0] ADDR_RAM_LAST      = 8'h2f;
  localparam logic [7:0] ADDR_ONES_LAST     = 8'h7f;
  localparam logic [7:0] ADDR_UNDEF_LAST    = 8'h9f;
  localparam logic [7:0] ADDR_PERIPH_FIRST  = 8'ha0;
  localparam logic [7:0] ADDR_PERIPH_LAST   = 8'hee;
  localparam logic [7:0] ADDR_PSW           = 8'hef;
  localparam logic [7:0] ADDR_REGRAM_FIRST  = 8'hf0;
  localparam logic [7:0] ADDR_REGRAM_LAST   = 8'hfb;
  localparam logic [7:0] ADDR_PTR_SECONDARY = 8'hfc;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'hfd;
  localparam logic [7:0] ADDR_PTR_PRIMARY   = 8'hfe;
  localparam logic [7:0] ADDR_SPARE_REG     = 8'hff;

  // ****************************************************************
  // Storage sizes and indices
  // ****************************************************************
  localparam int unsigned RAM_BYTES      = 48;
  localparam int unsigned REGRAM_BYTES   = 13;
  localparam logic [3:0]  REGRAM_SPARE_IX = 4'hc;

  // ****************************************************************
  // Read values and reset values
  // ****************************************************************
  localparam logic [7:0] DATA_ONES     = 8'hff;
  localparam logic [7:0] DATA_UNDEF    = 8'h00;
  localparam logic [7:0] SP_RESET      = 8'h2f;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [7:0] PSW_RESET     = 8'h00;
  localparam logic [7:0] ACC_RESET     = 8'h00;
  localparam logic [14:0] PC_RESET     = 15'h0000;

  // ****************************************************************
  // Status word fields and jump limits
  // ****************************************************************
  localparam int unsigned PSW_GIE_BIT   = 0;
  localparam int unsigned PSW_HALF_BIT  = 6;
  localparam int unsigned PSW_CARRY_BIT = 7;
  localparam logic signed [6:0] REL_MIN = -7'sd31;
  localparam logic signed [6:0] REL_MAX = 7'sd32;

  // ****************************************************************
  // Commands and pointer steps
  // ****************************************************************
  typedef enum logic [3:0] {
    KIND_LOAD_OP,
    KIND_EXCHANGE,
    KIND_STORE,
    KIND_LOAD_IMMEDIATE,
    KIND_LOAD_PTR_SHORT,
    KIND_LOAD_TABLE_INDIRECT,
    KIND_JUMP_RELATIVE_SHORT,
    KIND_JUMP_ABSOLUTE,
    KIND_JUMP_ABSOLUTE_LONG,
    KIND_JUMP_TABLE_INDIRECT,
    KIND_VECTOR_DISPATCH,
    KIND_NO_OPERATION
  } cag_kind_t;

  typedef enum logic [1:0] {
    STEP_NONE,
    STEP_INC,
    STEP_DEC
  } cag_step_t;

endpackage

// ==== rtl/cag_ram.sv ====
// Flip-flop byte storage with one write port and one read port
`timescale 1ns/1ps
module cag_ram
  import cag_pkg::*;
#(
  parameter int unsigned DEPTH = RAM_BYTES,
  parameter int unsigned IW    = 6
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              wr_en,
  input  wire logic [IW-1:0]     wr_idx,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [IW-1:0]     rd_idx,
  output logic      [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem_q [DEPTH];

  // ****************************************************************
  // Storage entries
  // ****************************************************************
  // Cleared at reset so simulation never reads unknown bytes
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        mem_q[i] <= 8'h00;
      end else if (wr_en && (wr_idx == IW'(i))) begin
        mem_q[i] <= wr_data;
      end
    end
  end

  // Index beyond depth reads zero; the caller decodes the range
  always_comb begin
    rd_data = 8'h00;
    if (32'(rd_idx) < DEPTH) begin
      rd_data = mem_q[rd_idx];
    end
  end

endmodule

// ==== rtl/cag_pc_target.sv ====
// Branch target arithmetic for the 15-bit program counter
`timescale 1ns/1ps
module cag_pc_target
  import cag_pkg::*;
(
  input  wire cag_kind_t         kind,
  input  wire logic [PC_W-1:0]   pc,
  input  wire logic [PC_W-1:0]   field,
  output logic      [PC_W-1:0]   target,
  output logic                   in_range
);

  logic signed [6:0] disp;

  // ****************************************************************
  // Target selection
  // ****************************************************************
  // Relative adds wrap over the whole space, so no paging occurs
  always_comb begin
    disp     = signed'(field[6:0]);
    target   = pc;
    in_range = 1'b1;
    if (kind == KIND_JUMP_RELATIVE_SHORT) begin
      if ((disp < REL_MIN) || (disp > REL_MAX)) begin
        in_range = 1'b0;
      end else begin
        target = pc + {{(PC_W-7){disp[6]}}, disp};
      end
    end else if (kind == KIND_JUMP_ABSOLUTE) begin
      target = {pc[PC_W-1:ABS_W], field[ABS_W-1:0]};
    end else if (kind == KIND_JUMP_ABSOLUTE_LONG) begin
      target = field;
    end else if (kind == KIND_NO_OPERATION) begin
      target = pc + 15'h0001;
    end
  end

endmodule

// ==== rtl/cag_top.sv ====
// Operand and branch address generation with data memory decode
`timescale 1ns/1ps
module cag_top
  import cag_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              cmd_valid,
  input  wire cag_kind_t         cmd_kind,
  input  wire logic              cmd_indirect,
  input  wire logic              cmd_ptr_sel,
  input  wire cag_step_t         cmd_step,
  input  wire logic [PC_W-1:0]   cmd_field,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_data,
  output logic                   jump_refused,
  output logic      [PC_W-1:0]   program_counter,
  output logic                   prog_rd,
  output logic      [PC_W-1:0]   prog_addr,
  input  wire logic [DATA_W-1:0] prog_rdata,
  output logic                   periph_rd,
  output logic                   periph_wr,
  output logic      [DATA_W-1:0] periph_addr,
  output logic      [DATA_W-1:0] periph_wdata,
  input  wire logic [DATA_W-1:0] periph_rdata,
  output logic      [DATA_W-1:0] working_register,
  output logic      [DATA_W-1:0] stack_pointer,
  output logic                   carry_flag,
  output logic                   half_carry_flag,
  output logic                   global_irq_enable
);

  typedef enum logic [1:0] {S_IDLE, S_DATA, S_PREQ, S_PDATA} cag_state_t;

  // ****************************************************************
  // State
  // ****************************************************************
  cag_state_t        state_q, state_d;
  cag_kind_t         kind_q, kind_d;
  cag_step_t         step_q, step_d;
  logic              ind_q, ind_d, psel_q, psel_d;
  logic [PC_W-1:0]   field_q, field_d, pc_q, pc_d;
  logic [PC_W-1:0]   paddr_q, paddr_d;
  logic [7:0]        addr_q, addr_d, wdata_q, wdata_d;
  logic [7:0]        acc_q, acc_d, pri_q, pri_d, sec_q, sec_d;
  logic [7:0]        sp_q, sp_d, psw_q, psw_d, vhi_q, vhi_d;
  logic [7:0]        rdat_q, rdat_d;
  logic              second_q, second_d, rv_q, rv_d, ref_q, ref_d;
  logic              prd_q, prd_d, pwr_q, pwr_d, pxr_q, pxr_d;
  logic              rdy_q, rdy_d;
  logic              take, is_read, is_write, c_read, c_write;
  logic [7:0]        cmd_addr, rd_data, ram_rdata, reg_rdata;
  logic              ram_we, reg_we, in_ram, in_reg, c_periph;
  logic [3:0]        reg_idx;
  logic [PC_W-1:0]   tgt;
  logic              tgt_ok;

  assign take    = (state_q == S_IDLE) && cmd_valid;
  assign is_read = (kind_q == KIND_LOAD_OP) || (kind_q == KIND_EXCHANGE);
  assign is_write = (kind_q == KIND_STORE) || (kind_q == KIND_EXCHANGE);
  assign c_read  = (cmd_kind == KIND_LOAD_OP) || (cmd_kind == KIND_EXCHANGE);
  assign c_write = (cmd_kind == KIND_STORE) || (cmd_kind == KIND_EXCHANGE);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Indirect takes a pointer, direct takes the byte field unchanged
  assign cmd_addr = cmd_indirect ? (cmd_ptr_sel ? sec_q : pri_q)
                                 : cmd_field[7:0];
  assign c_periph = (cmd_addr >= ADDR_PERIPH_FIRST) &&
                    (cmd_addr <= ADDR_PERIPH_LAST);
  assign in_ram   = (addr_q <= ADDR_RAM_LAST);
  // Spare address FF maps to its own register byte, index c, after those of F0-FB
  assign in_reg   = ((addr_q >= ADDR_REGRAM_FIRST) &&
                     (addr_q <= ADDR_REGRAM_LAST)) ||
                    (addr_q == ADDR_SPARE_REG);
  assign reg_idx  = (addr_q == ADDR_SPARE_REG) ? REGRAM_SPARE_IX
                                               : addr_q[3:0];

  // Read multiplexer over the whole data map
  always_comb begin
    if (in_ram) begin
      rd_data = ram_rdata;
    end else if (addr_q <= ADDR_ONES_LAST) begin
      rd_data = DATA_ONES;
    end else if (addr_q <= ADDR_UNDEF_LAST) begin
      rd_data = DATA_UNDEF;
    end else if (addr_q <= ADDR_PERIPH_LAST) begin
      rd_data = periph_rdata;
    end else if (addr_q == ADDR_PSW) begin
      rd_data = psw_q;
    end else if (addr_q == ADDR_PTR_SECONDARY) begin
      rd_data = sec_q;
    end else if (addr_q == ADDR_STACK_POINTER) begin
      rd_data = sp_q;
    end else if (addr_q == ADDR_PTR_PRIMARY) begin
      rd_data = pri_q;
    end else begin
      rd_data = reg_rdata;
    end
  end

  // ****************************************************************
  // Storage and target arithmetic
  // ****************************************************************
  cag_ram #(.DEPTH(RAM_BYTES), .IW(6)) u_ram (
    .clock   (clock),
    .resetn  (resetn),
    .wr_en   (ram_we),
    .wr_idx  (addr_q[5:0]),
    .wr_data (wdata_q),
    .rd_idx  (addr_q[5:0]),
    .rd_data (ram_rdata)
  );

  cag_ram #(.DEPTH(REGRAM_BYTES), .IW(4)) u_regram (
    .clock   (clock),
    .resetn  (resetn),
    .wr_en   (reg_we),
    .wr_idx  (reg_idx),
    .wr_data (wdata_q),
    .rd_idx  (reg_idx),
    .rd_data (reg_rdata)
  );

  cag_pc_target u_target (
    .kind     (kind_q),
    .pc       (pc_q),
    .field    (field_q),
    .target   (tgt),
    .in_range (tgt_ok)
  );

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;  kind_d = kind_q;   step_d = step_q;
    ind_d   = ind_q;    psel_d = psel_q;   field_d = field_q;
    pc_d    = pc_q;     paddr_d = paddr_q; addr_d = addr_q;
    wdata_d = wdata_q;  acc_d = acc_q;     pri_d = pri_q;
    sec_d   = sec_q;    sp_d = sp_q;       psw_d = psw_q;
    vhi_d   = vhi_q;    rdat_d = rdat_q;   second_d = second_q;
    rv_d = 1'b0; ref_d = 1'b0; prd_d = 1'b0; pwr_d = 1'b0; pxr_d = 1'b0;
    ram_we = 1'b0; reg_we = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (cmd_valid) begin
          kind_d  = cmd_kind;  step_d = cmd_step;  ind_d = cmd_indirect;
          psel_d  = cmd_ptr_sel;  field_d = cmd_field;  addr_d = cmd_addr;
          // Exchange writes the old working register value
          wdata_d = (cmd_kind == KIND_EXCHANGE) ? acc_q : cmd_wdata;
          pxr_d   = c_periph && c_read;
          pwr_d   = c_periph && c_write;
          second_d = 1'b0;
          if (cmd_kind == KIND_LOAD_TABLE_INDIRECT ||
              cmd_kind == KIND_JUMP_TABLE_INDIRECT) begin
            paddr_d = {pc_q[PC_W-1:8], acc_q};
            prd_d   = 1'b1;
            state_d = S_PREQ;
          end else if (cmd_kind == KIND_VECTOR_DISPATCH) begin
            paddr_d = cmd_field;
            prd_d   = 1'b1;
            state_d = S_PREQ;
          end else begin
            state_d = S_DATA;
          end
        end
      end
      S_DATA: begin
        state_d = S_IDLE;
        rv_d    = 1'b1;
        if (is_read) begin
          acc_d  = rd_data;
          rdat_d = rd_data;
        end
        if (is_write) begin
          ram_we = in_ram;
          reg_we = in_reg;
          if (addr_q == ADDR_PSW) psw_d = wdata_q;
          if (addr_q == ADDR_PTR_SECONDARY) sec_d = wdata_q;
          if (addr_q == ADDR_STACK_POINTER) sp_d = wdata_q;
          if (addr_q == ADDR_PTR_PRIMARY) pri_d = wdata_q;
        end
        // Step from the address used, so it wraps at 8 bits; a step
        // wins over an exchange that wrote the pointer itself
        if (is_read && ind_q && step_q != STEP_NONE) begin
          if (psel_q) begin
            sec_d = (step_q == STEP_INC) ? addr_q + 8'h01
                                         : addr_q - 8'h01;
          end else begin
            pri_d = (step_q == STEP_INC) ? addr_q + 8'h01
                                         : addr_q - 8'h01;
          end
        end
        if (kind_q == KIND_LOAD_IMMEDIATE) begin
          acc_d  = field_q[7:0];
          rdat_d = field_q[7:0];
        end
        if (kind_q == KIND_LOAD_PTR_SHORT) begin
          pri_d = {4'h0, field_q[3:0]};
        end
        if (kind_q == KIND_JUMP_RELATIVE_SHORT ||
            kind_q == KIND_JUMP_ABSOLUTE ||
            kind_q == KIND_JUMP_ABSOLUTE_LONG ||
            kind_q == KIND_NO_OPERATION) begin
          ref_d = !tgt_ok;
          if (tgt_ok) pc_d = tgt;
        end
      end
      S_PREQ: begin
        state_d = S_PDATA;
      end
      S_PDATA: begin
        state_d = S_IDLE;
        rv_d    = 1'b1;
        if (kind_q == KIND_LOAD_TABLE_INDIRECT) begin
          acc_d  = prog_rdata;
          rdat_d = prog_rdata;
        end else if (kind_q == KIND_JUMP_TABLE_INDIRECT) begin
          pc_d = {pc_q[PC_W-1:8], prog_rdata};
        end else if (!second_q) begin
          // First vector byte is the upper part; fetch its neighbour
          vhi_d    = prog_rdata;
          second_d = 1'b1;
          paddr_d  = paddr_q + 15'h0001;
          prd_d    = 1'b1;
          rv_d     = 1'b0;
          state_d  = S_PREQ;
        end else begin
          pc_d = {vhi_q[PC_UPPER_W-1:0], prog_rdata};
        end
      end
    endcase
    rdy_d = (state_d == S_IDLE);
  end

  // ****************************************************************
  // Sequencer registers
  // ****************************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;  kind_q <= KIND_NO_OPERATION;  step_q <= STEP_NONE;
      ind_q <= 1'b0;  psel_q <= 1'b0;  field_q <= '0;  pc_q <= PC_RESET;
      paddr_q <= '0;  addr_q <= 8'h00;  wdata_q <= 8'h00;
      acc_q <= ACC_RESET;  pri_q <= PTR_RESET;  sec_q <= PTR_RESET;
      sp_q <= SP_RESET;
      psw_q <= PSW_RESET;  vhi_q <= 8'h00;  rdat_q <= 8'h00;
      second_q <= 1'b0;  rv_q <= 1'b0;  ref_q <= 1'b0;  prd_q <= 1'b0;
      pwr_q <= 1'b0;  pxr_q <= 1'b0;  rdy_q <= 1'b0;
    end else begin
      state_q <= state_d;  kind_q <= kind_d;  step_q <= step_d;
      ind_q <= ind_d;  psel_q <= psel_d;  field_q <= field_d;  pc_q <= pc_d;
      paddr_q <= paddr_d;  addr_q <= addr_d;  wdata_q <= wdata_d;
      acc_q <= acc_d;  pri_q <= pri_d;  sec_q <= sec_d;
      sp_q <= sp_d;  psw_q <= psw_d;  vhi_q <= vhi_d;  rdat_q <= rdat_d;
      second_q <= second_d;  rv_q <= rv_d;  ref_q <= ref_d;  prd_q <= prd_d;
      pwr_q <= pwr_d;  pxr_q <= pxr_d;  rdy_q <= rdy_d;
    end
  end

  // Outputs are plain register taps
  assign cmd_ready         = rdy_q;
  assign rsp_valid         = rv_q;
  assign rsp_data          = rdat_q;
  assign jump_refused      = ref_q;
  assign program_counter   = pc_q;
  assign prog_rd           = prd_q;
  assign prog_addr         = paddr_q;
  assign periph_rd         = pxr_q;
  assign periph_wr         = pwr_q;
  assign periph_addr       = addr_q;
  assign periph_wdata      = wdata_q;
  assign working_register  = acc_q;
  assign stack_pointer     = sp_q;
  assign carry_flag        = psw_q[PSW_CARRY_BIT];
  assign half_carry_flag   = psw_q[PSW_HALF_BIT];
  assign global_irq_enable = psw_q[PSW_GIE_BIT];

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic first_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) first_q <= 1'b1;
    else         first_q <= 1'b0;
  end

  chk_sp_reset: assert property (@(posedge clock) disable iff (!resetn)
    first_q |-> sp_q == 8'h2f)
    else $error("stack pointer not 2f after reset");

  chk_ones_read: assert property (@(posedge clock) disable iff (!resetn)
    (take && cmd_kind == KIND_LOAD_OP && !cmd_indirect &&
     cmd_field[7:0] >= 8'h30 && cmd_field[7:0] <= 8'h7f)
    |-> ##2 rsp_valid && rsp_data == 8'hff)
    else $error("unused range did not read all ones");

  chk_direct_addr: assert property (@(posedge clock) disable iff (!resetn)
    (take && !cmd_indirect) |=> addr_q == $past(cmd_field[7:0]))
    else $error("direct address altered");

  chk_post_step: assert property (@(posedge clock) disable iff (!resetn)
    (take && cmd_kind == KIND_LOAD_OP && cmd_indirect &&
     cmd_step == STEP_DEC) |-> ##2 ($past(cmd_ptr_sel, 2) ?
     sec_q == $past(sec_q, 2) - 8'h01 : pri_q == $past(pri_q, 2) - 8'h01))
    else $error("post decrement missing");

  chk_store_nostep: assert property (@(posedge clock) disable iff (!resetn)
    (take && cmd_kind == KIND_STORE && cmd_indirect &&
     (cmd_ptr_sel ? sec_q : pri_q) < 8'hf0) |-> ##2
    pri_q == $past(pri_q, 2) && sec_q == $past(sec_q, 2))
    else $error("store stepped a pointer");

  chk_imm_load: assert property (@(posedge clock) disable iff (!resetn)
    (take && cmd_kind == KIND_LOAD_IMMEDIATE)
    |-> ##2 acc_q == $past(cmd_field[7:0], 2))
    else $error("immediate operand wrong");

  chk_short_imm: assert property (@(posedge clock) disable iff (!resetn)
    (take && cmd_kind == KIND_LOAD_PTR_SHORT)
    |-> ##2 pri_q == {4'h0, $past(cmd_field[3:0], 2)})
    else $error("short immediate wrong");

  chk_abs_jump: assert property (@(posedge clock) disable iff (!resetn)
    (take && cmd_kind == KIND_JUMP_ABSOLUTE) |-> ##2
    pc_q == {$past(pc_q[14:12], 2), $past(cmd_field[11:0], 2)})
    else $error("absolute jump left upper bits wrong");

  chk_long_jump: assert property (@(posedge clock) disable iff (!resetn)
    (take && cmd_kind == KIND_JUMP_ABSOLUTE_LONG)
    |-> ##2 pc_q == $past(cmd_field, 2))
    else $error("long jump target wrong");

  chk_rel_jump: assert property (@(posedge clock) disable iff (!resetn)
    (take && cmd_kind == KIND_JUMP_RELATIVE_SHORT &&
     cmd_field[6:0] == 7'h61) |-> ##2 pc_q == $past(pc_q, 2) - 15'h001f)
    else $error("relative jump of -31 wrong");

  chk_rel_refuse: assert property (@(posedge clock) disable iff (!resetn)
    (take && cmd_kind == KIND_JUMP_RELATIVE_SHORT &&
     cmd_field[6:0] == 7'h60) |-> ##2 jump_refused && $stable(pc_q))
    else $error("out of range jump taken");

  chk_table_addr: assert property (@(posedge clock) disable iff (!resetn)
    (take && cmd_kind == KIND_LOAD_TABLE_INDIRECT)
    |=> prog_rd && prog_addr[7:0] == $past(acc_q) ##2 acc_q == $past(prog_rdata))
    else $error("table load address or data wrong");

endmodule

// ==== tb/cag_mem_model.sv ====
// Program memory and peripheral responder for the address generator
`timescale 1ns/1ps
module cag_mem_model
  import cag_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              prog_rd,
  input  wire logic [PC_W-1:0]   prog_addr,
  output logic      [DATA_W-1:0] prog_rdata,
  input  wire logic              periph_rd,
  input  wire logic [DATA_W-1:0] periph_addr,
  output logic      [DATA_W-1:0] periph_rdata
);
  initial prog_rdata = 8'h00;
  // Synchronous ROM; idle cycles invert so a stale byte never passes
  always @(posedge clock) begin
    if (prog_rd) begin
      prog_rdata <= prog_addr[7:0] ^ {1'b0, prog_addr[14:8]};
    end else begin
      prog_rdata <= ~prog_rdata;
    end
  end
  // Peripheral returns the inverted address while selected, the address itself otherwise
  assign periph_rdata = periph_rd ? ~periph_addr : periph_addr;
endmodule

// ==== tb/cag_top_tb.sv ====
// Self-checking bench for the address generation block
`timescale 1ns/1ps
module cag_top_tb import cag_pkg::*; ;
  logic clock, resetn, cmd_valid, cmd_indirect, cmd_ptr_sel, refused;
  cag_kind_t cmd_kind;
  cag_step_t cmd_step;
  logic [14:0] cmd_field, program_counter, prog_addr;
  logic [7:0] cmd_wdata, rsp_data, prog_rdata, periph_addr, periph_wdata;
  logic [7:0] periph_rdata, working_register, stack_pointer;
  logic cmd_ready, rsp_valid, jump_refused, prog_rd, periph_rd, periph_wr;
  logic carry_flag, half_carry_flag, global_irq_enable;
  int failures, num_checks, cycles;
  logic [7:0] ta [4] = '{8'h05, 8'h2f, 8'hfb, 8'hff};
  logic [7:0] pw_data = 8'h00;
  cag_top uut (.clock, .resetn, .cmd_valid, .cmd_kind, .cmd_indirect,
    .cmd_ptr_sel, .cmd_step, .cmd_field, .cmd_wdata, .cmd_ready,
    .rsp_valid, .rsp_data, .jump_refused, .program_counter, .prog_rd,
    .prog_addr, .prog_rdata, .periph_rd, .periph_wr, .periph_addr,
    .periph_wdata, .periph_rdata, .working_register, .stack_pointer,
    .carry_flag, .half_carry_flag, .global_irq_enable);
  cag_mem_model mem (.clock, .prog_rd, .prog_addr, .prog_rdata,
    .periph_rd, .periph_addr, .periph_rdata);
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  // Capture the byte forwarded to one peripheral address
  always @(negedge clock) begin
    if (periph_wr && periph_addr == 8'hc8) pw_data = periph_wdata;
  end
  // ********************
  // Access tasks
  // ********************
  function logic [7:0] rom(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]};
  endfunction
  task wrap_up();
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [14:0] seen, input logic [14:0] e);
    num_checks++;
    if (seen !== e) begin
      failures++;
      $display("[FAIL] %s exp %h seen %h", nm, e, seen);
    end
  endtask
  // Hold the request until taken, then wait a bounded time for the answer
  task run(input cag_kind_t k, input logic ind, input logic sel,
           input cag_step_t s, input logic [14:0] f, input logic [7:0] w);
    int n;
    @(posedge clock) #1;
    cmd_kind = k;
    cmd_step = s;
    {cmd_indirect, cmd_ptr_sel} = {ind, sel};
    {cmd_field, cmd_wdata, cmd_valid} = {f, w, 1'b1};
    do @(negedge clock); while (cmd_ready !== 1'b1);
    @(posedge clock) #1 cmd_valid = 0;
    n = 0;
    do begin @(negedge clock); n++; end while (rsp_valid !== 1'b1 && n < 20);
    refused = jump_refused;
    chk("rsp_valid", rsp_valid, 1'b1);
  endtask
  task ld(input logic [7:0] a);
    run(KIND_LOAD_OP, 0, 0, STEP_NONE, {7'h00, a}, 8'h00);
  endtask
  task st(input logic [7:0] a, input logic [7:0] d);
    run(KIND_STORE, 0, 0, STEP_NONE, {7'h00, a}, d);
  endtask
  task jump_absolute(input cag_kind_t k, input logic [14:0] f, input logic [14:0] e);
    run(k, 0, 0, STEP_NONE, f, 8'h00);
    chk("pc", program_counter, e);
  endtask
  // Hang guard: sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end
  // ********************
  // Test sequence
  // ********************
  initial begin
    {cmd_valid, cmd_indirect, cmd_ptr_sel, resetn} = 4'h0;
    cmd_kind = KIND_NO_OPERATION;
    cmd_step = STEP_NONE;
    {cmd_field, cmd_wdata} = 23'h0;
    repeat (4) @(posedge clock);
    chk("sp", stack_pointer, 8'h2f);
    #1 resetn = 1;
    for (int i = 0; i < 4; i++) begin
      st(ta[i], ta[i] ^ 8'h96);
      ld(ta[i]);
      chk("ram", rsp_data, ta[i] ^ 8'h96);
    end
    ld(8'h30);
    chk("ones", rsp_data, 8'hff);
    ld(8'h7f);
    chk("ones", rsp_data, 8'hff);
    ld(8'hc8);
    chk("periph", rsp_data, 8'h37);
    st(8'hc8, 8'h5a);
    chk("pwr", pw_data, 8'h5a);
    ld(8'hfd);
    chk("sp map", rsp_data, 8'h2f);
    st(8'hef, 8'h81);
    chk("carry", carry_flag, 1'b1);
    chk("half", half_carry_flag, 1'b0);
    chk("gie", global_irq_enable, 1'b1);
    ld(8'hef);
    chk("psw", rsp_data, 8'h81);
    run(KIND_LOAD_PTR_SHORT, 0, 0, STEP_NONE, 15'h7ff5, 8'h00);
    ld(8'hfe);
    chk("short", rsp_data, 8'h05);
    // Store must not step the pointer
    run(KIND_STORE, 1, 0, STEP_INC, 15'h0, 8'h11);
    ld(8'hfe);
    chk("no step", rsp_data, 8'h05);
    ld(8'h05);
    chk("ind st", rsp_data, 8'h11);
    st(8'hfe, 8'hff);
    run(KIND_LOAD_OP, 1, 0, STEP_INC, 15'h0, 8'h00);
    chk("ind ld", rsp_data, 8'h69);
    ld(8'hfe);
    chk("wrap", rsp_data, 8'h00);
    run(KIND_LOAD_OP, 1, 1, STEP_DEC, 15'h0, 8'h00);
    ld(8'hfc);
    chk("wrap dec", rsp_data, 8'hff);
    run(KIND_LOAD_IMMEDIATE, 0, 0, STEP_NONE, 15'h0080, 8'h00);
    chk("imm", rsp_data, 8'h80);
    chk("acc", working_register, 8'h80);
    jump_absolute(KIND_JUMP_ABSOLUTE_LONG, 15'h7ff0, 15'h7ff0);
    run(KIND_LOAD_TABLE_INDIRECT, 0, 0, STEP_NONE, 15'h0, 8'h00);
    chk("table", rsp_data, rom(15'h7f80));
    jump_absolute(KIND_JUMP_RELATIVE_SHORT, 15'h0020, 15'h0010);
    jump_absolute(KIND_JUMP_RELATIVE_SHORT, 15'h0060, 15'h0010);
    chk("refused", refused, 1'b1);
    jump_absolute(KIND_JUMP_RELATIVE_SHORT, 15'h0061, 15'h7ff1);
    jump_absolute(KIND_JUMP_ABSOLUTE, 15'h0123, 15'h7123);
    jump_absolute(KIND_JUMP_TABLE_INDIRECT, 15'h0, {7'h71, rom(15'h71ff)});
    jump_absolute(KIND_VECTOR_DISPATCH, 15'h1234, 15'h2627);
    jump_absolute(KIND_NO_OPERATION, 15'h0, 15'h2628);
    run(KIND_EXCHANGE, 0, 0, STEP_NONE, 15'h0005, 8'h00);
    chk("xch", rsp_data, 8'h11);
    ld(8'h05);
    chk("xch mem", rsp_data, 8'hff);
    wrap_up();
  end
endmodule
